// [bench/uart_async_ext_assertions.sv]
// port checker for the uart extension block
// assumes one-cycle register strobes from a plain master
`timescale 1ns/1ps
`default_nettype none
module uart_async_ext_assertions
   import uart_ext_pkg::*;
(
   input wire logic       I_MCLK,    // clock
   input wire logic       I_RESET_N, // sync reset
   input wire logic [2:0] I_ADDR,    // offset
   input wire logic [7:0] I_WDATA,   // data
   input wire logic       I_WR,      // write
   input wire logic       I_RD,      // read
   input wire logic [7:0] O_RDATA,   // read data
   input wire logic       O_TXD_OUT, // pin value
   input wire logic       O_TXD_OE,  // pin enable
   input wire logic       O_DRV_DIR  // direction
);
   logic [1:0] a_q, a_d;   // loopback, rs485 copies
   logic [5:0] b_q, b_d;   // second control copy
   logic [7:0] hi_q, hi_d; // cycles since pin last pulled low
   wire logic  low = O_TXD_OE && !O_TXD_OUT;
   // shadows follow writes, so no internal taps are needed
   always_comb begin
      a_d = a_q;
      b_d = b_q;
      hi_d = low ? 8'h00 : hi_q + {7'h00, hi_q != 8'hff};
      if (I_WR && I_ADDR == REG_CTRLA) a_d = I_WDATA[1:0];
      if (I_WR && I_ADDR == REG_CTRL2) b_d = I_WDATA[5:0];
      if (!I_RESET_N) begin
         a_d = 2'h0;
         b_d = 6'h00;
         hi_d = 8'hff;
      end
   end
   always_ff @(posedge I_MCLK) begin
      a_q <= a_d;
      b_q <= b_d;
      hi_q <= hi_d;
   end
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RESET_N);
   AST_RESET_OUT: assert property ($rose(I_RESET_N) |-> O_TXD_OUT && !O_TXD_OE && !O_DRV_DIR && O_RDATA == 8'h00)
      else $error("outputs not at reset values");
   AST_RDATA_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
      else $error("read data outside its cycle");
   AST_OD_NO_HIGH: assert property ($stable(b_q) && b_q[B_OPEN_DRAIN] |-> !O_TXD_OUT)
      else $error("open drain drove the pin high");
   AST_OE_TXEN: assert property ($stable(b_q) && !b_q[B_OPEN_DRAIN] |-> O_TXD_OE == b_q[B_TXEN])
      else $error("pin enable differs from transmitter enable");
   AST_NO_DIR: assert property ($stable(a_q) && !a_q[A_RS485] |-> !O_DRV_DIR)
      else $error("direction high with rs485 off");
   AST_DIR_START: assert property (I_WR && I_ADDR == REG_TXDATA && a_q[A_RS485] && b_q[B_TXEN] && !O_DRV_DIR
      |=> O_DRV_DIR) else $error("direction did not rise after send");
   AST_DIR_GUARD: assert property ($rose(O_DRV_DIR) |-> !low [*8])
      else $error("data before guard time");
   AST_DIR_HOLD: assert property ($fell(O_DRV_DIR) |-> hi_q >= 8'h06)
      else $error("direction fell inside the frame");
   AST_IDLE_QUIET: assert property (a_q[A_RS485] && !O_DRV_DIR && !$past(O_DRV_DIR) |-> !low)
      else $error("pin pulled low outside a frame");
endmodule : uart_async_ext_assertions
bind uart_async_ext uart_async_ext_assertions CHK (
   .I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
   .I_RD(I_RD), .O_RDATA(O_RDATA), .O_TXD_OUT(O_TXD_OUT), .O_TXD_OE(O_TXD_OE), .O_DRV_DIR(O_DRV_DIR)
);
`default_nettype wire

// [bench/uart_async_ext_bench.sv]
// self-checking bench for the uart extension block
// assumes the remote node model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module uart_async_ext_bench import uart_ext_pkg::*;;
   logic       mclk = 1'b0;
   logic       reset_n = 1'b0;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic       rxd, txd_out, txd_oe, drv_dir, got_oe;
   int         fail_count = 0;
   int         checked = 0;
   int         n;
   wire logic  txd_in = txd_oe ? txd_out : 1'b1; // pull-up holds the released wire high
   // mode, clocks per bit, byte sent, status expected
   logic [31:0] rows [4] = '{32'h00_80_a5_01, 32'h01_40_3c_01, 32'h00_80_00_01, 32'h01_40_ff_01};
   always #5 mclk = ~mclk;
   uart_remote_node NODE (.i_clk(mclk), .o_line(rxd));
   uart_async_ext DUT (
      .I_MCLK(mclk), .I_RESET_N(reset_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
      .O_RDATA(rdata), .I_RXD(rxd), .I_TXD_IN(txd_in), .O_TXD_OUT(txd_out), .O_TXD_OE(txd_oe),
      .O_DRV_DIR(drv_dir)
   );
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wreg
   // read data sampled at the edge that closes its only valid cycle
   task automatic rchk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
      chk(rdata & m, e);
   endtask : rchk
   task automatic do_reset();
      @(posedge mclk);
      reset_n <= 1'b0;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
   endtask : do_reset
   // break, gap, sync byte, then idle long enough for any stray frame
   task automatic brk_sync(input int len, input logic [7:0] b, input int per);
      NODE.level(1'b0, len);
      NODE.level(1'b1, 300);
      NODE.send(b, per, 1'b1);
      NODE.level(1'b1, 1500);
   endtask : brk_sync
   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // cuts a hang short
   initial begin
      repeat (100000) @(posedge mclk);
      fail_count++;
      end_of_test();
   end
   initial begin
      do_reset();
      for (int a = 0; a < 8; a++) rchk(3'(a), a == 6 ? 8'h04 : 8'h00); // reset values, unmapped reads 0
      foreach (rows[i]) begin
         wreg(REG_CTRL2, 8'h08 | rows[i][31:24]);
         NODE.send(rows[i][15:8], int'(rows[i][23:16]), 1'b1);
         rchk(REG_STATUS, rows[i][7:0]);
         rchk(REG_RXDATA, rows[i][15:8]);
      end
      wreg(REG_CTRL2, 8'h08);
      NODE.send(8'h5a, 128, 1'b0);
      rchk(REG_STATUS, 8'h03);
      rchk(REG_RXDATA, 8'h5a);
      NODE.level(1'b0, 20);
      NODE.level(1'b1, 1500); // long enough that a wrongly accepted start would finish its frame
      rchk(REG_STATUS, 8'h02);
      // generic auto-baud: 100 clocks a bit gives 800
      do_reset();
      wreg(REG_CTRL2, 8'h0a);
      brk_sync(1500, 8'h55, 100);
      rchk(REG_BAUDL, 8'h20);
      rchk(REG_BAUDH, 8'h03);
      wreg(REG_STATUS, 8'h08);
      brk_sync(5, 8'h55, 10);
      rchk(REG_BAUDL, 8'h20);
      rchk(REG_STATUS, 8'h00, 8'h08);
      wreg(REG_STATUS, 8'h08);
      brk_sync(5, 8'h55, 20);
      rchk(REG_BAUDL, 8'ha0);
      rchk(REG_BAUDH, 8'h00);
      // lin: uneven sync edges must leave the divisor alone
      do_reset();
      wreg(REG_CTRL2, 8'h0b);
      brk_sync(1500, 8'h54, 128);
      NODE.send(8'hff, 128, 1'b1);
      NODE.level(1'b1, 1500);
      rchk(REG_STATUS, 8'h04, 8'h04);
      rchk(REG_BAUDH, 8'h04);
      // zero frame with low stop re-arms; a clean sync at 64 clocks a bit gives 0x0200
      NODE.send(8'h00, 128, 1'b0);
      brk_sync(1500, 8'h55, 64);
      rchk(REG_BAUDH, 8'h02);
      // one wire, open drain, rs485, two stops; receive pin held low
      do_reset();
      wreg(REG_CTRLA, 8'h03);
      wreg(REG_CTRL2, 8'h3c);
      NODE.level(1'b0, 1);
      wreg(REG_TXDATA, 8'hc6);
      n = 0;
      got_oe = 1'b0;
      for (int i = 0; i < 3000 && (n == 0 || drv_dir); i++) begin
         @(posedge mclk);
         n += int'(drv_dir);
         got_oe |= txd_oe;
      end
      chk(8'(n >= 1528 && n <= 1537), 8'h01);
      chk(8'(got_oe), 8'h01);
      rchk(REG_STATUS, 8'h01);
      rchk(REG_RXDATA, 8'hc6);
      end_of_test();
   end
endmodule : uart_async_ext_bench
`default_nettype wire

// [bench/uart_remote_node.sv]
// remote serial node driving the receive line of the uart block
// assumes its tasks are entered right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module uart_remote_node (
   input  wire logic i_clk, // bench clock
   output logic      o_line // serial line, idle high
);
   initial o_line = 1'b1;
   // hold a level v for n clocks
   task automatic level(input logic v, input int n);
      o_line <= v;
      repeat (n) @(posedge i_clk);
   endtask : level
   // start, eight data bits lsb first, chosen stop level, one idle bit
   task automatic send(input logic [7:0] b, input int per, input logic stop);
      level(1'b0, per);
      for (int i = 0; i < 8; i++) level(b[i], per);
      level(stop, per);
      level(1'b1, per);
   endtask : send
endmodule : uart_remote_node
`default_nettype wire

// [hw/uart_async_ext.sv]
// asynchronous uart receiver with double speed, auto-baud, one-wire and rs-485
// assumes pins synchronous to I_MCLK and a one-cycle strobe register port
// Operation
// - receive mode value one selects double speed, doubling the rate
// - double speed takes eight samples per bit instead of sixteen
// - vote starts at sample eight normally, sample four in double speed
// - middle vote sample is nine normally, five in double speed
// - auto-baud: twelve low cycles mean break, then measure sync character
// - after break count clocks over eight bit times; count becomes divisor
// - generic mode wait-for-break flag accepts break of any length
// - generic mode updates divisor only for counts 0x0064 to 0xffff
// - lin mode ignores wait-for-break; break needs twelve low cycles
// - lin mode: sync not 0x55 sets mismatch flag, rate unchanged
// - loopback routes transmit pin to receiver, receive pin disconnected
// - open drain never drives pin high, only pulls low
// - open drain makes transmit pin an output automatically
// - one-wire receiver captures the device's own frames when receive is enabled and no break hunt is armed
// - rs-485 direction pin high while sending, low when done
// - direction rises one bit before data and spans all stop bits
// - rs-485 direction and one-wire loopback work together
// - start bit accepted only if two of three votes are low
// - only first stop bit checked; low sets frame error
`timescale 1ns/1ps
`default_nettype none
module uart_async_ext
   import uart_ext_pkg::*;
(
   input  wire logic       I_MCLK,    // peripheral clock, 100 MHz
   input  wire logic       I_RESET_N, // sync reset, active low
   input  wire logic [2:0] I_ADDR,    // register offset
   input  wire logic [7:0] I_WDATA,   // write data
   input  wire logic       I_WR,      // write strobe
   input  wire logic       I_RD,      // read strobe
   output logic      [7:0] O_RDATA,   // read data, cycle after I_RD
   input  wire logic       I_RXD,     // receive pin
   input  wire logic       I_TXD_IN,  // level seen on transmit pin
   output logic            O_TXD_OUT, // transmit pin value
   output logic            O_TXD_OE,  // transmit pin enable
   output logic            O_DRV_DIR  // line driver direction
);
   typedef enum logic [2:0] {R_IDLE, R_START, R_FRAME, R_STOP, R_BRK, R_SYNC_WAIT, R_SYNC_MEAS} rx_state_t;

   // control registers and read data
   logic [1:0]  ctla_q, ctla_d;
   logic [5:0]  ctlb_q, ctlb_d;
   logic [7:0]  rdat_d;
   // receiver, status and divisor
   rx_state_t   st_q, st_d;
   logic [7:0]  sh_q, sh_d, rxd_q, rxd_d;
   logic [2:0]  idx_q, idx_d, falls_q, falls_d;
   logic [3:0]  lowc_q, lowc_d;
   logic [16:0] meas_q, meas_d, first_q, first_d, acc_q, acc_d, acc_n;
   logic [15:0] baud_q, baud_d;
   logic        arm_q, arm_d, wbk_q, wbk_d, isf_q, isf_d, ferr_q, ferr_d, rdy_q, rdy_d;
   logic        line_q, prev_q, tick_q, tick_d;
   // helpers
   logic [1:0]  mode;
   logic [18:0] quad, diff;
   logic        fall, restart, vote_valid, vote_bit, busy, generic, auto, brk_ok;
   logic        sync_ok, meas_ok, tx_start, wr_st, rd_rx;

   assign mode     = ctlb_q[B_MODE_HI:B_MODE_LO];
   assign generic  = (mode == RXM_GENERIC);
   assign auto     = generic || (mode == RXM_LIN);
   assign fall     = prev_q & ~line_q;
   assign wr_st    = I_WR && (I_ADDR == REG_STATUS);
   assign rd_rx    = I_RD && (I_ADDR == REG_RXDATA);
   // a write while a frame is going out is dropped
   assign tx_start = I_WR && (I_ADDR == REG_TXDATA) && !busy;

   // register writes and the registered read mux
   always_comb begin
      ctla_d = ctla_q;
      ctlb_d = ctlb_q;
      rdat_d = 8'h00;
      if (I_WR && I_ADDR == REG_CTRLA) ctla_d = I_WDATA[1:0];
      if (I_WR && I_ADDR == REG_CTRL2) ctlb_d = I_WDATA[5:0];
      if (I_RD) begin
         unique case (I_ADDR)
            REG_CTRLA:  rdat_d = {6'h00, ctla_q};
            REG_CTRL2:  rdat_d = {2'h0, ctlb_q};
            REG_STATUS: rdat_d = {3'h0, busy, wbk_q, isf_q, ferr_q, rdy_q};
            REG_RXDATA: rdat_d = rxd_q;
            REG_BAUDL:  rdat_d = baud_q[7:0];
            REG_BAUDH:  rdat_d = baud_q[15:8];
            default:    rdat_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RESET_N) begin
         ctla_q  <= 2'h0;
         ctlb_q  <= 6'h00;
         O_RDATA <= 8'h00;
      end else begin
         ctla_q  <= ctla_d;
         ctlb_q  <= ctlb_d;
         O_RDATA <= rdat_d;
      end
   end

   // sample tick: 128 samples per measured divisor, i.e. per eight normal bits;
   // double speed keeps the tick rate and halves samples per bit
   always_comb begin
      acc_n  = acc_q + SAMPLES_PER_8;
      acc_d  = acc_n;
      tick_d = 1'b0;
      if (acc_n >= {1'b0, baud_q}) begin
         acc_d  = acc_n - {1'b0, baud_q};
         tick_d = 1'b1;
         // divisors below 128 would need several ticks a clock; cap at one
         if (acc_d >= {1'b0, baud_q}) acc_d = 17'h00000;
      end
   end

   // sync check: first falling-edge interval spans two of the eight bits
   always_comb begin
      quad    = {first_q, 2'b00};
      diff    = (quad > {2'b00, meas_q}) ? quad - {2'b00, meas_q} : {2'b00, meas_q} - quad;
      sync_ok = (diff <= {5'h00, meas_q[16:3]});
      meas_ok = (meas_q >= BAUD_MIN) && (meas_q <= BAUD_MAX);
      brk_ok  = (lowc_q >= BRK_LOW_CYCLES) || (generic && wbk_q);
   end

   // receiver sequencing, status flags and divisor
   always_comb begin
      st_d = st_q; sh_d = sh_q; idx_d = idx_q; lowc_d = lowc_q; meas_d = meas_q;
      first_d = first_q; falls_d = falls_q; arm_d = arm_q; wbk_d = wbk_q;
      isf_d = isf_q; ferr_d = ferr_q; rdy_d = rdy_q; rxd_d = rxd_q; baud_d = baud_q;
      restart = 1'b0;
      // software clears come first so a hardware set in the same cycle wins
      if (wr_st) begin
         if (I_WDATA[S_SYNC_ERR]) isf_d = 1'b0;
         if (I_WDATA[S_FRAME_ERR]) ferr_d = 1'b0;
         if (I_WDATA[S_WAIT_BREAK]) wbk_d = 1'b1;
      end
      if (rd_rx) rdy_d = 1'b0;
      if (I_WR && I_ADDR == REG_BAUDL) baud_d[7:0] = I_WDATA;
      if (I_WR && I_ADDR == REG_BAUDH) baud_d[15:8] = I_WDATA;
      unique case (st_q)
         R_IDLE: begin
            if (ctlb_q[B_RXEN] && fall) begin
               if (auto && (arm_q || (generic && wbk_q))) begin
                  st_d   = R_BRK;
                  lowc_d = 4'h1;
               end else begin
                  st_d    = R_START;
                  restart = 1'b1;
               end
            end
         end
         R_START: if (vote_valid) begin
            st_d  = vote_bit ? R_IDLE : R_FRAME;
            idx_d = 3'h0;
         end
         R_FRAME: if (vote_valid) begin
            sh_d  = {vote_bit, sh_q[7:1]};
            idx_d = idx_q + 3'h1;
            if (idx_q == 3'h7) st_d = R_STOP;
         end
         R_STOP: if (vote_valid) begin
            // later stop bits are never looked at
            rxd_d = sh_q;
            rdy_d = 1'b1;
            if (!vote_bit) ferr_d = 1'b1;
            if (auto && !vote_bit && sh_q == RESET_BYTE) arm_d = 1'b1;  // zero frame re-arms break hunt
            st_d = R_IDLE;
         end
         R_BRK: begin
            if (!line_q) begin
               if (lowc_q != 4'hf) lowc_d = lowc_q + 4'h1;
            end else if (brk_ok) begin
               st_d  = R_SYNC_WAIT;
               wbk_d = 1'b0;
            end else begin
               st_d = R_IDLE;                                           // too short
            end
         end
         R_SYNC_WAIT: if (fall) begin
            st_d    = R_SYNC_MEAS;
            meas_d  = 17'h00001;
            falls_d = 3'h1;
         end
         R_SYNC_MEAS: begin
            if (meas_q != MEAS_SAT) meas_d = meas_q + 17'h00001;
            if (fall) begin
               falls_d = falls_q + 3'h1;
               if (falls_q == 3'h1) first_d = meas_q;
               if (falls_q + 3'h1 == SYNC_FALLS) begin
                  // eighth bit time ends at the fifth falling edge
                  st_d  = R_IDLE;
                  arm_d = 1'b0;
                  if (generic) begin
                     if (meas_ok) baud_d = meas_q[15:0];
                  end else if (sync_ok && meas_q <= BAUD_MAX) begin
                     baud_d = meas_q[15:0];
                  end else begin
                     isf_d = 1'b1;
                  end
               end
            end else if (meas_q == MEAS_SAT) begin
               st_d = R_IDLE;                                           // line stuck
               if (!generic) isf_d = 1'b1;
            end
         end
         default: st_d = R_IDLE;
      endcase
   end

   always_ff @(posedge I_MCLK) begin
      if (!I_RESET_N) begin
         st_q    <= R_IDLE;
         sh_q    <= RESET_BYTE;
         rxd_q   <= RESET_BYTE;
         idx_q   <= 3'h0;
         falls_q <= 3'h0;
         lowc_q  <= 4'h0;
         meas_q  <= 17'h00000;
         first_q <= 17'h00000;
         acc_q   <= 17'h00000;
         tick_q  <= 1'b0;
         baud_q  <= BAUD_RESET;
         arm_q   <= 1'b1;
         wbk_q   <= 1'b0;
         isf_q   <= 1'b0;
         ferr_q  <= 1'b0;
         rdy_q   <= 1'b0;
         line_q  <= 1'b1;
         prev_q  <= 1'b1;
      end else begin
         st_q    <= st_d;
         sh_q    <= sh_d;
         rxd_q   <= rxd_d;
         idx_q   <= idx_d;
         falls_q <= falls_d;
         lowc_q  <= lowc_d;
         meas_q  <= meas_d;
         first_q <= first_d;
         acc_q   <= acc_d;
         tick_q  <= tick_d;
         baud_q  <= baud_d;
         arm_q   <= arm_d;
         wbk_q   <= wbk_d;
         isf_q   <= isf_d;
         ferr_q  <= ferr_d;
         rdy_q   <= rdy_d;
         // one-wire: the transmit pin level, own frames included, feeds the receiver
         line_q  <= ctla_q[A_LOOPBACK] ? I_TXD_IN : I_RXD;
         prev_q  <= line_q;
      end
   end

   // vote timing follows the selected sampling rate
   uart_vote u_vote (
      .i_clk        (I_MCLK),
      .i_reset_n    (I_RESET_N),
      .i_tick       (tick_q),
      .i_restart    (restart),
      .i_dbl        (mode == RXM_DOUBLE),
      .i_line       (line_q),
      .o_vote_valid (vote_valid),
      .o_vote_bit   (vote_bit)
   );

   // direction control stays independent of the loopback path
   uart_txer u_tx (
      .i_clk      (I_MCLK),
      .i_reset_n  (I_RESET_N),
      .i_tick     (tick_q),
      .i_dbl      (mode == RXM_DOUBLE),
      .i_start    (tx_start),
      .i_data     (I_WDATA),
      .i_two_stop (ctlb_q[B_TWO_STOP]),
      .i_rs485    (ctla_q[A_RS485]),
      .i_drain    (ctlb_q[B_OPEN_DRAIN]),
      .i_txen     (ctlb_q[B_TXEN]),
      .o_out      (O_TXD_OUT),
      .o_oe       (O_TXD_OE),
      .o_dir      (O_DRV_DIR),
      .o_busy     (busy)
   );
endmodule : uart_async_ext
`default_nettype wire

// [hw/uart_txer.sv]
// transmit shifter with rs-485 direction and open-drain pin drive
// assumes the same sample ticks as the receiver
`timescale 1ns/1ps
`default_nettype none
module uart_txer
   import uart_ext_pkg::*;
(
   input  wire logic       i_clk,      // peripheral clock
   input  wire logic       i_reset_n,  // sync reset, active low
   input  wire logic       i_tick,     // one sample tick
   input  wire logic       i_dbl,      // double-speed bit length
   input  wire logic       i_start,    // pulse: send i_data
   input  wire logic [7:0] i_data,     // byte to send
   input  wire logic       i_two_stop, // two stop bits
   input  wire logic       i_rs485,    // direction pin control
   input  wire logic       i_drain,    // open-drain drive
   input  wire logic       i_txen,     // transmitter enable
   output logic            o_out,      // pin output value
   output logic            o_oe,       // pin output enable
   output logic            o_dir,      // line driver direction
   output logic            o_busy      // frame in progress
);
   typedef enum logic [2:0] {T_IDLE, T_GUARD, T_START, T_DATA, T_STOP} tx_state_t;
   tx_state_t  st_q, st_d;
   logic [4:0] cnt_q, cnt_d;
   logic [2:0] idx_q, idx_d;
   logic [7:0] sh_q, sh_d;
   logic       stop2_q, stop2_d, level, out_d, oe_d, dir_d;

   // bit sequencing; the guard bit gives the line driver time to turn on
   always_comb begin
      st_d = st_q; cnt_d = cnt_q; idx_d = idx_q; sh_d = sh_q; stop2_d = stop2_q;
      dir_d = o_dir;
      if (st_q == T_IDLE) begin
         if (i_start) begin
            st_d    = i_rs485 ? T_GUARD : T_START;
            dir_d   = i_rs485;
            cnt_d   = 5'h00;
            sh_d    = i_data;
            idx_d   = 3'h0;
            stop2_d = i_two_stop;
         end
      end else if (i_tick) begin
         cnt_d = cnt_q + SAMPLE_FIRST;
         if (cnt_d == (i_dbl ? SPB_DOUBLE : SPB_NORMAL)) begin
            cnt_d = 5'h00;
            unique case (st_q)
               T_GUARD: st_d = T_START;
               T_START: st_d = T_DATA;
               T_DATA: begin
                  sh_d  = {1'b1, sh_q[7:1]};
                  idx_d = idx_q + 3'h1;
                  if (idx_q == 3'h7) st_d = T_STOP;
               end
               T_STOP: begin
                  if (stop2_q) begin
                     stop2_d = 1'b0;
                  end else begin
                     st_d  = T_IDLE;
                     dir_d = 1'b0;               // held through all stops
                  end
               end
               default: st_d = T_IDLE;
            endcase
         end
      end
      level = (st_d == T_START) ? 1'b0 : (st_d == T_DATA) ? sh_d[0] : 1'b1;
      // open drain only ever pulls low, and then owns the pin direction
      out_d = i_drain ? 1'b0 : level;
      oe_d  = i_drain ? ~level : i_txen;
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         st_q    <= T_IDLE;
         cnt_q   <= 5'h00;
         idx_q   <= 3'h0;
         sh_q    <= RESET_BYTE;
         stop2_q <= 1'b0;
         o_out   <= 1'b1;
         o_oe    <= 1'b0;
         o_dir   <= 1'b0;
         o_busy  <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         idx_q   <= idx_d;
         sh_q    <= sh_d;
         stop2_q <= stop2_d;
         o_out   <= out_d;
         o_oe    <= oe_d;
         o_dir   <= dir_d;
         o_busy  <= (st_d != T_IDLE);
      end
   end
endmodule : uart_txer
`default_nettype wire

// [hw/uart_vote.sv]
// per-bit sample counter and three-sample majority vote
// assumes sample ticks from the shared baud accumulator
`timescale 1ns/1ps
`default_nettype none
module uart_vote
   import uart_ext_pkg::*;
(
   input  wire logic i_clk,        // peripheral clock
   input  wire logic i_reset_n,    // sync reset, active low
   input  wire logic i_tick,       // one sample tick
   input  wire logic i_restart,    // first low sample of a start bit
   input  wire logic i_dbl,        // double-speed sampling
   input  wire logic i_line,       // receive line level
   output logic      o_vote_valid, // pulse: bit decided
   output logic      o_vote_bit    // majority value
);
   logic [4:0] cnt_q, cnt_d, nxt, spb, first, mid;
   logic [1:0] votes_q, votes_d;
   logic       valid_d, bit_d;

   function automatic logic majority(input logic a, input logic b, input logic c);
      majority = (a & b) | (a & c) | (b & c);
   endfunction : majority

   // sample number of the tick now being taken
   always_comb begin
      spb   = i_dbl ? SPB_DOUBLE : SPB_NORMAL;
      first = i_dbl ? FIRST_DOUBLE : FIRST_NORMAL;
      mid   = i_dbl ? MID_DOUBLE : MID_NORMAL;
      nxt   = (cnt_q == spb) ? SAMPLE_FIRST : cnt_q + SAMPLE_FIRST;
      cnt_d   = cnt_q;
      votes_d = votes_q;
      valid_d = 1'b0;
      bit_d   = o_vote_bit;
      if (i_restart) begin
         cnt_d = SAMPLE_FIRST;
      end else if (i_tick) begin
         cnt_d = nxt;
         if (nxt == first) votes_d[0] = i_line;
         if (nxt == mid) votes_d[1] = i_line;
         if (nxt == mid + SAMPLE_FIRST) begin
            valid_d = 1'b1;
            bit_d   = majority(votes_q[0], votes_q[1], i_line);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         cnt_q        <= SAMPLE_FIRST;
         votes_q      <= 2'h3;
         o_vote_valid <= 1'b0;
         o_vote_bit   <= 1'b1;
      end else begin
         cnt_q        <= cnt_d;
         votes_q      <= votes_d;
         o_vote_valid <= valid_d;
         o_vote_bit   <= bit_d;
      end
   end
endmodule : uart_vote
`default_nettype wire

// [include/uart_ext_pkg.sv]
// constants shared by the asynchronous uart extension block
// assumes an 8-bit register port and one peripheral clock
package uart_ext_pkg;
   // register offsets on the plain register port
   localparam logic [2:0] REG_CTRLA  = 3'h0;
   localparam logic [2:0] REG_CTRL2  = 3'h1;
   localparam logic [2:0] REG_STATUS = 3'h2;
   localparam logic [2:0] REG_RXDATA = 3'h3;
   localparam logic [2:0] REG_TXDATA = 3'h4;
   localparam logic [2:0] REG_BAUDL  = 3'h5;
   localparam logic [2:0] REG_BAUDH  = 3'h6;
   // field positions
   localparam int A_LOOPBACK   = 0;
   localparam int A_RS485      = 1;
   localparam int B_MODE_LO    = 0;
   localparam int B_MODE_HI    = 1;
   localparam int B_OPEN_DRAIN = 2;
   localparam int B_RXEN       = 3;
   localparam int B_TXEN       = 4;
   localparam int B_TWO_STOP   = 5;
   localparam int S_RX_READY   = 0;
   localparam int S_FRAME_ERR  = 1;
   localparam int S_SYNC_ERR   = 2;
   localparam int S_WAIT_BREAK = 3;
   localparam int S_TX_BUSY    = 4;
   // receive mode select encodings
   localparam logic [1:0] RXM_NORMAL  = 2'h0;
   localparam logic [1:0] RXM_DOUBLE  = 2'h1;
   localparam logic [1:0] RXM_GENERIC = 2'h2;
   localparam logic [1:0] RXM_LIN     = 2'h3;
   // samples per bit and vote positions
   localparam logic [4:0] SPB_NORMAL   = 5'h10;
   localparam logic [4:0] SPB_DOUBLE   = 5'h08;
   localparam logic [4:0] FIRST_NORMAL = 5'h08;
   localparam logic [4:0] FIRST_DOUBLE = 5'h04;
   localparam logic [4:0] MID_NORMAL   = 5'h09;
   localparam logic [4:0] MID_DOUBLE   = 5'h05;
   localparam logic [4:0] SAMPLE_FIRST = 5'h01;
   // auto-baud figures
   localparam logic [3:0]  BRK_LOW_CYCLES = 4'hc;
   localparam logic [2:0]  SYNC_FALLS     = 3'h5;
   localparam logic [16:0] BAUD_MIN       = 17'h00064;
   localparam logic [16:0] BAUD_MAX       = 17'h0ffff;
   localparam logic [16:0] MEAS_SAT       = 17'h1ffff;
   localparam logic [16:0] SAMPLES_PER_8  = 17'h00080;
   localparam logic [15:0] BAUD_RESET     = 16'h0400;
   localparam logic [7:0]  RESET_BYTE     = 8'h00;
endpackage : uart_ext_pkg
